// ### rtl/cfd_pkg.sv
// constants shared by the configuration fuse decoder
//
// Overview of operation
// - Threshold field bits 4:3 of the first byte picks the trip level, 11 lowest and 00 highest.
// - Brown-out mode 11 keeps brown-out reset always on and ignores the software enable.
// - Brown-out mode 10 keeps brown-out reset on except in sleep and ignores the software enable.
// - Brown-out mode 01 turns brown-out reset on only while the software enable is set.
// - Brown-out mode 00 keeps brown-out reset off whatever software does.
// - Power-up delay enable at bit 0 of the first byte is active low.
// - Power-up delay and brown-out reset are decoded independently of each other.
// - Watchdog postscale field bits 4:1 selects a divide ratio of two to the power of the code.
// - Watchdog runs when the hardware enable is 1, else only while the software enable is set.
// - External reset pin enable 1 makes the shared pin a reset and blocks its input, 0 the reverse.
// - Secondary timer oscillator low-power bit set gives low power, clear gives higher power.
// - Port analog default bit sets the reset value of the analog config register for pins 4:0.
// - Capture/compare two mux bit routes it to port c pin one when set, port b pin three when clear.
// - Unimplemented bits of every configuration byte always read back as zero.
`default_nettype none

package cfd_pkg;

  // register indexes (byte address is four times the index)
  localparam logic [21:0] CFD_IDX_BOR_POWERUP_DELAY_TIMER = 22'h300002;
  localparam logic [21:0] CFD_IDX_WDOG     = 22'h300003;
  localparam logic [21:0] CFD_IDX_PIN_OSC  = 22'h300005;
  localparam logic [21:0] CFD_IDX_DBG_CORE = 22'h300006;
  localparam logic [21:0] CFD_IDX_SW_CTRL  = 22'h300010;
  localparam logic [21:0] CFD_IDX_STATUS   = 22'h300011;

  // implemented-bit masks per configuration byte
  localparam logic [7:0] CFD_MASK_BOR_POWERUP_DELAY_TIMER = 8'h1f;
  localparam logic [7:0] CFD_MASK_WDOG     = 8'h1f;
  localparam logic [7:0] CFD_MASK_PIN_OSC  = 8'h87;
  localparam logic [7:0] CFD_MASK_DBG_CORE = 8'hfd;

  // unprogrammed values of each byte
  localparam logic [7:0] CFD_BLANK_BOR_POWERUP_DELAY_TIMER = 8'h1f;
  localparam logic [7:0] CFD_BLANK_WDOG     = 8'h1f;
  localparam logic [7:0] CFD_BLANK_PIN_OSC  = 8'h87;
  localparam logic [7:0] CFD_BLANK_DBG_CORE = 8'hbd;

  // field positions, first byte
  localparam int CFD_BORV_HI   = 4;
  localparam int CFD_BORV_LO   = 3;
  localparam int CFD_BOREN_HI  = 2;
  localparam int CFD_BOREN_LO  = 1;
  localparam int CFD_POWERUP_DELAY_ENABLE_N_N  = 0;
  // second byte
  localparam int CFD_WDPS_HI   = 4;
  localparam int CFD_WDPS_LO   = 1;
  localparam int CFD_WDEN      = 0;
  // third byte
  localparam int CFD_XRST_EN   = 7;
  localparam int CFD_T1_LOWPWR = 2;
  localparam int CFD_PB_ANALOG = 1;
  localparam int CFD_CAPTURE_COMPARE_TWO_MUX  = 0;
  // fourth byte
  localparam int CFD_EXTENDED_INSTR_ENABLE     = 6;
  localparam int CFD_DBGPORT   = 3;

  // software control register bits
  localparam int CFD_SW_BOR    = 0;
  localparam int CFD_SW_WDOG   = 1;
  localparam logic [1:0] CFD_SW_RESET = 2'h0;

  // brown-out enable modes
  localparam logic [1:0] CFD_BOR_ALWAYS   = 2'h3;
  localparam logic [1:0] CFD_BOR_NO_SLEEP = 2'h2;
  localparam logic [1:0] CFD_BOR_SOFTWARE = 2'h1;
  localparam logic [1:0] CFD_BOR_OFF      = 2'h0;

  localparam int CFD_ANALOG_PINS = 5;

endpackage : cfd_pkg

`default_nettype wire

// ### rtl/cfd_sample.sv
// one-shot capture of the configuration bytes after reset release
`default_nettype none

module cfd_sample
  import cfd_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pclken,
  input  wire logic       nvm_programmed,
  input  wire logic [7:0] nvm_bor_powerup_delay_timer,
  input  wire logic [7:0] nvm_wdog,
  input  wire logic [7:0] nvm_pin_osc,
  input  wire logic [7:0] nvm_dbg_core,
  output logic            loaded_r,
  output logic [31:0]     cfg_r
);

  localparam logic [31:0] MASK  = {CFD_MASK_DBG_CORE, CFD_MASK_PIN_OSC,
                                   CFD_MASK_WDOG, CFD_MASK_BOR_POWERUP_DELAY_TIMER};
  localparam logic [31:0] BLANK = {CFD_BLANK_DBG_CORE, CFD_BLANK_PIN_OSC,
                                   CFD_BLANK_WDOG, CFD_BLANK_BOR_POWERUP_DELAY_TIMER};

  logic [31:0] raw;
  logic [31:0] cfg_nxt;

  assign raw = {nvm_dbg_core, nvm_pin_osc, nvm_wdog, nvm_bor_powerup_delay_timer};

  // per bit: blank storage gives the unprogrammed value, holes read zero
  genvar b;
  generate
    for (b = 0; b < 32; b++) begin : g_bit
      assign cfg_nxt[b] = MASK[b] &
                          (nvm_programmed ? raw[b] : BLANK[b]);
    end
  endgenerate

  // capture once at the first enabled edge after release, then freeze;
  // constants under reset so no port value reaches the async path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_r <= 1'b0;
      cfg_r    <= BLANK & MASK;
    end else if (pclken && !loaded_r) begin
      loaded_r <= 1'b1;
      cfg_r    <= cfg_nxt;
    end
  end

endmodule // cfd_sample

`default_nettype wire

// ### rtl/cfd_top.sv
// configuration fuse decoder with apb register access
`default_nettype none

module cfd_top
  import cfd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclken,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [23:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // nonvolatile storage
  input  wire logic        nvm_programmed,
  input  wire logic [7:0]  nvm_bor_powerup_delay_timer,
  input  wire logic [7:0]  nvm_wdog,
  input  wire logic [7:0]  nvm_pin_osc,
  input  wire logic [7:0]  nvm_dbg_core,
  // device state seen by the decoder
  input  wire logic        sleep_active,
  input  wire logic        ext_reset_pin_n,
  // decoded controls
  output logic             cfg_loaded,
  output logic [1:0]       brownout_threshold_sel,
  output logic             brownout_reset_active,
  output logic             powerup_delay_timer_en,
  output logic [3:0]       watchdog_postscale_sel,
  output logic [15:0]      watchdog_divide_ratio,
  output logic             watchdog_timer_run,
  output logic             ext_reset_req,
  output logic             port_e_pin_three_in,
  output logic             sec_timer_osc_lowpower,
  output logic [4:0]       analog_config_reset_val,
  output logic             capcomp2_on_port_c_pin_one,
  output logic             capcomp2_on_port_b_pin_three,
  output logic             dedicated_debug_port_enable,
  output logic             extended_instr_enable
);

  logic        loaded;
  logic [31:0] cfg;
  logic [7:0]  byte_bor_powerup_delay_timer;
  logic [7:0]  byte_wdog;
  logic [7:0]  byte_pin_osc;
  logic [7:0]  byte_dbg_core;
  logic [1:0]  sw_ctrl_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [21:0] idx;
  logic        addr_aligned;
  logic        hit_cfg;
  logic        hit_sw;
  logic        hit_status;
  logic        setup;
  logic        wr_commit;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [1:0]  bor_mode;
  logic        bor_nxt;
  logic [31:0] status_word;

  // decoded outputs, all registered
  logic        cfg_loaded_r;
  logic [1:0]  bor_thr_r;
  logic        bor_act_r;
  logic        powerup_delay_timer_en_r;
  logic [3:0]  wd_ps_r;
  logic [15:0] wd_div_r;
  logic        wd_run_r;
  logic        xrst_req_r;
  logic        pe3_in_r;
  logic        t1_lp_r;
  logic [4:0]  analog_rst_r;
  logic        capture_compare_two_c1_r;
  logic        capture_compare_two_b3_r;
  logic        dbg_port_r;
  logic        extended_instr_enable_r;

  // configuration bytes are caught once and never written from the bus
  cfd_sample u_sample (
    .pclk           (pclk),
    .presetn        (presetn),
    .pclken         (pclken),
    .nvm_programmed (nvm_programmed),
    .nvm_bor_powerup_delay_timer   (nvm_bor_powerup_delay_timer),
    .nvm_wdog       (nvm_wdog),
    .nvm_pin_osc    (nvm_pin_osc),
    .nvm_dbg_core   (nvm_dbg_core),
    .loaded_r       (loaded),
    .cfg_r          (cfg)
  );

  assign byte_bor_powerup_delay_timer = cfg[7:0];
  assign byte_wdog     = cfg[15:8];
  assign byte_pin_osc  = cfg[23:16];
  assign byte_dbg_core = cfg[31:24];

  // address decode: word aligned index compare
  assign idx          = paddr[23:2];
  assign addr_aligned = (paddr[1:0] == 2'h0);
  assign hit_cfg      = addr_aligned &&
                        (idx == CFD_IDX_BOR_POWERUP_DELAY_TIMER || idx == CFD_IDX_WDOG ||
                         idx == CFD_IDX_PIN_OSC  || idx == CFD_IDX_DBG_CORE);
  assign hit_sw       = addr_aligned && (idx == CFD_IDX_SW_CTRL);
  assign hit_status   = addr_aligned && (idx == CFD_IDX_STATUS);
  assign setup        = psel && !penable;
  assign wr_commit    = psel && penable && pready_r && pwrite && hit_sw &&
                        pstrb[0];

  // decoded state for software to observe
  assign status_word = {17'h0_0000, extended_instr_enable_r, dbg_port_r, capture_compare_two_c1_r, t1_lp_r,
                        xrst_req_r, wd_run_r, wd_ps_r, powerup_delay_timer_en_r, bor_act_r,
                        bor_thr_r, cfg_loaded_r};

  // read mux; config bytes are read-only, so writing them is an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (!addr_aligned) begin
      rd_err = 1'b1;
    end else if (idx == CFD_IDX_BOR_POWERUP_DELAY_TIMER) begin
      rd_data = {24'h000000, byte_bor_powerup_delay_timer};
      rd_err  = pwrite;
    end else if (idx == CFD_IDX_WDOG) begin
      rd_data = {24'h000000, byte_wdog};
      rd_err  = pwrite;
    end else if (idx == CFD_IDX_PIN_OSC) begin
      rd_data = {24'h000000, byte_pin_osc};
      rd_err  = pwrite;
    end else if (idx == CFD_IDX_DBG_CORE) begin
      rd_data = {24'h000000, byte_dbg_core};
      rd_err  = pwrite;
    end else if (hit_sw) begin
      rd_data = {30'h0000_0000, sw_ctrl_r};
    end else if (hit_status) begin
      rd_data = status_word;
      rd_err  = pwrite;
    end else begin
      rd_err = 1'b1; // unmapped
    end
  end

  // apb answer: prepared in setup, one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (pclken) begin
      if (setup) begin
        pready_r  <= 1'b1;
        prdata_r  <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr_r <= rd_err;
      end else begin
        pready_r  <= 1'b0;
        prdata_r  <= 32'h0000_0000;
        pslverr_r <= 1'b0;
      end
    end
  end

  // software enables for brown-out and watchdog, low byte lane only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_ctrl_r <= CFD_SW_RESET;
    end else if (pclken && wr_commit) begin
      sw_ctrl_r <= pwdata[1:0];
    end
  end

  // brown-out enable decode; mode 01 is the only one that hears software
  assign bor_mode = byte_bor_powerup_delay_timer[CFD_BOREN_HI:CFD_BOREN_LO];
  always_comb begin
    unique case (bor_mode)
      CFD_BOR_ALWAYS:   bor_nxt = 1'b1;
      CFD_BOR_NO_SLEEP: bor_nxt = !sleep_active;
      CFD_BOR_SOFTWARE: bor_nxt = sw_ctrl_r[CFD_SW_BOR];
      CFD_BOR_OFF:      bor_nxt = 1'b0;
    endcase
  end

  // brown-out and power-up timer outputs, each from its own field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bor_thr_r <= 2'h0;
      bor_act_r <= 1'b0;
      powerup_delay_timer_en_r <= 1'b0;
    end else if (pclken) begin
      bor_thr_r <= byte_bor_powerup_delay_timer[CFD_BORV_HI:CFD_BORV_LO];
      bor_act_r <= loaded && bor_nxt;
      powerup_delay_timer_en_r <= loaded && !byte_bor_powerup_delay_timer[CFD_POWERUP_DELAY_ENABLE_N_N];
    end
  end

  // watchdog: ratio is a one-hot power of two of the postscale code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_ps_r  <= 4'h0;
      wd_div_r <= 16'h0001;
      wd_run_r <= 1'b0;
    end else if (pclken) begin
      wd_ps_r  <= byte_wdog[CFD_WDPS_HI:CFD_WDPS_LO];
      wd_div_r <= 16'h0001 << byte_wdog[CFD_WDPS_HI:CFD_WDPS_LO];
      wd_run_r <= loaded && (byte_wdog[CFD_WDEN] ||
                             sw_ctrl_r[CFD_SW_WDOG]);
    end
  end

  // shared reset pin: exactly one of the two functions sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xrst_req_r <= 1'b0;
      pe3_in_r   <= 1'b0;
    end else if (pclken) begin
      if (byte_pin_osc[CFD_XRST_EN]) begin
        xrst_req_r <= loaded && !ext_reset_pin_n;
        pe3_in_r   <= 1'b0;
      end else begin
        xrst_req_r <= 1'b0;
        pe3_in_r   <= ext_reset_pin_n;
      end
    end
  end

  // oscillator, analog default and pin routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_lp_r      <= 1'b0;
      analog_rst_r <= 5'h00;
      capture_compare_two_c1_r    <= 1'b0;
      capture_compare_two_b3_r    <= 1'b0;
    end else if (pclken) begin
      t1_lp_r      <= byte_pin_osc[CFD_T1_LOWPWR];
      // the analog register loads this at its own reset, so keep it steady
      analog_rst_r <= {CFD_ANALOG_PINS{byte_pin_osc[CFD_PB_ANALOG]}};
      capture_compare_two_c1_r    <= loaded && byte_pin_osc[CFD_CAPTURE_COMPARE_TWO_MUX];
      capture_compare_two_b3_r    <= loaded && !byte_pin_osc[CFD_CAPTURE_COMPARE_TWO_MUX];
    end
  end

  // debug port and core options; the debug bit is passed as programmed,
  // keeping it clear on small variants is left to the programmer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_port_r   <= 1'b0;
      extended_instr_enable_r      <= 1'b0;
      cfg_loaded_r <= 1'b0;
    end else if (pclken) begin
      dbg_port_r   <= byte_dbg_core[CFD_DBGPORT];
      extended_instr_enable_r      <= byte_dbg_core[CFD_EXTENDED_INSTR_ENABLE];
      cfg_loaded_r <= loaded;
    end
  end

  assign pready                       = pready_r;
  assign prdata                       = prdata_r;
  assign pslverr                      = pslverr_r;
  assign cfg_loaded                   = cfg_loaded_r;
  assign brownout_threshold_sel       = bor_thr_r;
  assign brownout_reset_active        = bor_act_r;
  assign powerup_delay_timer_en       = powerup_delay_timer_en_r;
  assign watchdog_postscale_sel       = wd_ps_r;
  assign watchdog_divide_ratio        = wd_div_r;
  assign watchdog_timer_run           = wd_run_r;
  assign ext_reset_req                = xrst_req_r;
  assign port_e_pin_three_in          = pe3_in_r;
  assign sec_timer_osc_lowpower       = t1_lp_r;
  assign analog_config_reset_val      = analog_rst_r;
  assign capcomp2_on_port_c_pin_one   = capture_compare_two_c1_r;
  assign capcomp2_on_port_b_pin_three = capture_compare_two_b3_r;
  assign dedicated_debug_port_enable  = dbg_port_r;
  assign extended_instr_enable        = extended_instr_enable_r;

endmodule // cfd_top

`default_nettype wire

// ### tb/cfd_checker.sv
// assertions on the decoded outputs of the configuration fuse decoder
`default_nettype none

module cfd_checker
  import cfd_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pclken,
  input wire logic        nvm_programmed,
  input wire logic [7:0]  nvm_bor_powerup_delay_timer,
  input wire logic        sleep_active,
  input wire logic        ext_reset_pin_n,
  input wire logic        cfg_loaded,
  input wire logic [1:0]  brownout_threshold_sel,
  input wire logic        brownout_reset_active,
  input wire logic        powerup_delay_timer_en,
  input wire logic [3:0]  watchdog_postscale_sel,
  input wire logic [15:0] watchdog_divide_ratio,
  input wire logic        ext_reset_req,
  input wire logic        port_e_pin_three_in,
  input wire logic        capcomp2_on_port_c_pin_one,
  input wire logic        capcomp2_on_port_b_pin_three
);
  logic [7:0] b0_r;
  logic       taken_r;

  // own copy of the first byte, taken once, so later storage edits are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_r <= 1'b0;
      b0_r    <= 8'h1f;
    end else if (pclken && !taken_r) begin
      taken_r <= 1'b1;
      b0_r    <= nvm_programmed ? nvm_bor_powerup_delay_timer : 8'h1f;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bor_off: assert property (
    cfg_loaded && b0_r[2:1] == 2'h0 |-> !brownout_reset_active)
    else $error("brown-out reset on in off mode");
  a_bor_on: assert property (
    cfg_loaded && b0_r[2:1] == 2'h3 |-> brownout_reset_active)
    else $error("brown-out reset off in always mode");
  // a frozen cycle keeps the old decode, so only check after enabled edges
  a_bor_sleep: assert property (
    cfg_loaded && $past(pclken) && b0_r[2:1] == 2'h2
    |-> brownout_reset_active == !$past(sleep_active))
    else $error("brown-out reset wrong around sleep");
  a_powerup_delay_timer_bit: assert property (
    cfg_loaded |-> powerup_delay_timer_en == !b0_r[0])
    else $error("power-up delay enable wrong");
  a_thr_field: assert property (
    cfg_loaded |-> brownout_threshold_sel == b0_r[4:3])
    else $error("threshold field wrong");
  a_wd_ratio: assert property (
    cfg_loaded |-> watchdog_divide_ratio == 16'h1 << watchdog_postscale_sel)
    else $error("watchdog ratio wrong");
  a_capture_compare_two_excl: assert property (
    cfg_loaded |-> capcomp2_on_port_c_pin_one != capcomp2_on_port_b_pin_three)
    else $error("capture pin routing not exclusive");
  a_xrst_input: assert property (
    ext_reset_req |-> !port_e_pin_three_in &&
    (!$past(pclken) || !$past(ext_reset_pin_n)))
    else $error("external reset and pin input clash");
  a_cfg_hold: assert property (
    cfg_loaded && $past(cfg_loaded) |-> $stable(watchdog_postscale_sel)
    && $stable(capcomp2_on_port_c_pin_one))
    else $error("decoded output moved after load");
  a_loaded_keep: assert property (
    $rose(cfg_loaded) |=> cfg_loaded [*8])
    else $error("loaded flag dropped");
endmodule // cfd_checker

bind cfd_top cfd_checker u_cfd_checker (
  .pclk, .presetn, .pclken, .nvm_programmed, .nvm_bor_powerup_delay_timer, .sleep_active,
  .ext_reset_pin_n, .cfg_loaded, .brownout_threshold_sel,
  .brownout_reset_active, .powerup_delay_timer_en, .watchdog_postscale_sel,
  .watchdog_divide_ratio, .ext_reset_req, .port_e_pin_three_in,
  .capcomp2_on_port_c_pin_one, .capcomp2_on_port_b_pin_three
);

`default_nettype wire

// ### tb/cfd_nvm_model.sv
// model of the nonvolatile configuration storage
`default_nettype none

module cfd_nvm_model #(
  parameter bit LARGE_PKG = 1'b1
) (
  input  wire logic       programmed,
  input  wire logic [7:0] m0,
  input  wire logic [7:0] m1,
  input  wire logic [7:0] m2,
  input  wire logic [7:0] m3,
  output logic            nvm_programmed,
  output logic [7:0]      nvm_bor_powerup_delay_timer,
  output logic [7:0]      nvm_wdog,
  output logic [7:0]      nvm_pin_osc,
  output logic [7:0]      nvm_dbg_core
);
  // blank storage holds no usable data, so show junk the decoder must skip
  assign nvm_programmed = programmed;
  assign nvm_bor_powerup_delay_timer   = programmed ? m0 : ~m0;
  assign nvm_wdog       = programmed ? m1 : ~m1;
  assign nvm_pin_osc    = programmed ? m2 : ~m2;
  // small packages never get the debug port bit written
  assign nvm_dbg_core   = !programmed ? ~m3 :
                          LARGE_PKG ? m3 : (m3 & 8'hf7);
endmodule // cfd_nvm_model

`default_nettype wire

// ### tb/cfd_tb_top.sv
// self-checking testbench for the configuration fuse decoder
`default_nettype none

module cfd_tb_top
  import cfd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic       p;
    logic [7:0] b0, b1, b2, b3;
    logic       bor, wd;
  } cfd_row_s;

  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic        pclken = 1'b1;
  logic        penable = 1'b0, pwrite = 1'b0, programmed = 1'b1;
  logic        sleep_active = 1'b0, ext_reset_pin_n = 1'b0, err;
  logic [23:0] paddr = 24'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [7:0]  m0 = 8'h0, m1 = 8'h0, m2 = 8'h0, m3 = 8'h0;
  wire  [31:0] prdata;
  wire  [7:0]  nvm_bor_powerup_delay_timer, nvm_wdog, nvm_pin_osc, nvm_dbg_core;
  wire  [1:0]  brownout_threshold_sel;
  wire  [3:0]  watchdog_postscale_sel;
  wire  [15:0] watchdog_divide_ratio;
  wire  [4:0]  analog_config_reset_val;
  wire         pready, pslverr, nvm_programmed, cfg_loaded;
  wire         brownout_reset_active, powerup_delay_timer_en;
  wire         watchdog_timer_run, ext_reset_req, port_e_pin_three_in;
  wire         sec_timer_osc_lowpower, capcomp2_on_port_c_pin_one;
  wire         capcomp2_on_port_b_pin_three, extended_instr_enable;
  wire         dedicated_debug_port_enable;
  int          mismatches = 0, checks_done = 0;
  cfd_row_s    r;
  logic [7:0]  bv [4];
  logic [7:0]  mk [4] = '{CFD_MASK_BOR_POWERUP_DELAY_TIMER, CFD_MASK_WDOG,
                          CFD_MASK_PIN_OSC, CFD_MASK_DBG_CORE};
  logic [23:0] ad [4] = '{24'hc00008, 24'hc0000c, 24'hc00014, 24'hc00018};
  logic [23:0] bad [3] = '{24'hc00008, 24'hc00100, 24'hc00041};
  // row 0 is blank storage; rows cover all brown-out modes and
  // every pairing of power-up delay and brown-out enable
  cfd_row_s    rows [4] = '{
    '{1'b0, 8'h1f, 8'h1f, 8'h87, 8'hbd, 1'b1, 1'b1},
    '{1'b1, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0},
    '{1'b1, 8'hec, 8'he8, 8'hfd, 8'hf7, 1'b1, 1'b0},
    '{1'b1, 8'h13, 8'h0a, 8'h7a, 8'h48, 1'b0, 1'b0}};

  always #5 pclk = ~pclk;

  cfd_top dut (
    .pclk, .presetn, .pclken, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hf), .pready, .prdata, .pslverr, .nvm_programmed,
    .nvm_bor_powerup_delay_timer, .nvm_wdog, .nvm_pin_osc, .nvm_dbg_core, .sleep_active,
    .ext_reset_pin_n, .cfg_loaded, .brownout_threshold_sel,
    .brownout_reset_active, .powerup_delay_timer_en, .watchdog_postscale_sel,
    .watchdog_divide_ratio, .watchdog_timer_run, .ext_reset_req,
    .port_e_pin_three_in, .sec_timer_osc_lowpower, .analog_config_reset_val,
    .capcomp2_on_port_c_pin_one, .capcomp2_on_port_b_pin_three,
    .dedicated_debug_port_enable, .extended_instr_enable);

  cfd_nvm_model nvm (.programmed, .m0, .m1, .m2, .m3, .nvm_programmed,
    .nvm_bor_powerup_delay_timer, .nvm_wdog, .nvm_pin_osc, .nvm_dbg_core);

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer; reads pre-edge values, so no race with the slave
  task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // reset with new storage contents, then wait for the capture
  task automatic load(input cfd_row_s x);
    int n;
    n = 0;
    programmed <= x.p;
    {m0, m1, m2, m3} <= {x.b0, x.b1, x.b2, x.b3};
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (cfg_loaded !== 1'b1 && n < 20);
    if (cfg_loaded !== 1'b1) begin
      mismatches++;
      conclude();
    end
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      load(r);
      chk("thr", 32'(r.b0[4:3]),
          32'(brownout_threshold_sel));
      chk("bor", 32'(r.bor),
          32'(brownout_reset_active));
      chk("powerup_delay_timer", 32'(!r.b0[0]),
          32'(powerup_delay_timer_en));
      chk("ps", 32'(r.b1[4:1]),
          32'(watchdog_postscale_sel));
      chk("ratio", 32'(16'h1 << r.b1[4:1]),
          32'(watchdog_divide_ratio));
      chk("wd", 32'(r.wd), 32'(watchdog_timer_run));
      chk("xrst", {30'h0, r.b2[7], 1'b0},
          {30'h0, ext_reset_req, port_e_pin_three_in});
      chk("lp", 32'(r.b2[2]),
          32'(sec_timer_osc_lowpower));
      chk("an", 32'({5{r.b2[1]}}),
          32'(analog_config_reset_val));
      chk("ccp", {30'h0, r.b2[0], !r.b2[0]},
          {30'h0, capcomp2_on_port_c_pin_one,
           capcomp2_on_port_b_pin_three});
      chk("dbg", {30'h0, r.b3[6], r.b3[3]},
          {30'h0, extended_instr_enable,
           dedicated_debug_port_enable});
      bv = '{r.b0, r.b1, r.b2, r.b3};
      for (int j = 0; j < 4; j++) begin
        apb(1'b0, ad[j], 32'h0);
        chk("cfg_rd", 32'(bv[j] & mk[j]), rd);
      end
    end
    // software enables matter only in software-controlled modes
    apb(1'b1, 24'hc00040, 32'h3);
    repeat (2) @(posedge pclk);
    chk("bor_sw", 32'h1, 32'(brownout_reset_active));
    chk("wd_sw", 32'h1, 32'(watchdog_timer_run));
    ext_reset_pin_n <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("pin_in", 32'h1, 32'(port_e_pin_three_in));
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, bad[j], 32'hffffffff);
      chk("slverr", 32'h1, 32'(err));
    end
    apb(1'b0, 24'hc00040, 32'h0);
    chk("sw_rd", 32'h3, rd);
    // status: loaded, threshold 10, brown-out on, postscale 5,
    // watchdog on, debug port and extended bits set, the rest clear
    apb(1'b0, 24'hc00044, 32'h0);
    chk("status", 32'h0000_62ad, rd);
    apb(1'b0, 24'hc00008, 32'h0);
    chk("cfg_ro", 32'(r.b0 & CFD_MASK_BOR_POWERUP_DELAY_TIMER), rd);
    apb(1'b1, 24'hc00040, 32'h0);
    m0 <= 8'h18;
    repeat (3) @(posedge pclk);
    chk("bor_sw0", 32'h0, 32'(brownout_reset_active));
    chk("thr_hold", 32'(r.b0[4:3]),
        32'(brownout_threshold_sel));
    // sleep mode turns brown-out off; the software bit cannot revive it
    load(rows[2]);
    sleep_active <= 1'b1;
    apb(1'b1, 24'hc00040, 32'h1);
    repeat (2) @(posedge pclk);
    chk("bor_slp", 32'h0, 32'(brownout_reset_active));
    sleep_active <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("bor_wake", 32'h1, 32'(brownout_reset_active));
    // clock enable low freezes the decode even though sleep is entered
    pclken <= 1'b0;
    sleep_active <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("bor_frz", 32'h1, 32'(brownout_reset_active));
    pclken <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("bor_run", 32'h0, 32'(brownout_reset_active));
    conclude();
  end
endmodule // cfd_tb_top

`default_nettype wire
